// ==== src/cct_params.svh ====
// constants for the tunnel configuration block
// assumes a 200 MHz core clock
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

`define CCT_CLK_MHZ 200
`define CCT_US_CYC `CCT_CLK_MHZ

// register indices; byte address is four times the index
`define CCT_IDX_SUB_TIM 12'h040
`define CCT_IDX_MAIN_TIM 12'h041
`define CCT_IDX_XLATE_SOURCE_A 12'h042
`define CCT_IDX_XLATE_DEST_A 12'h043
`define CCT_IDX_XLATE_SOURCE_B 12'h044
`define CCT_IDX_XLATE_DEST_B 12'h045
`define CCT_IDX_UART_BYP 12'h048
`define CCT_IDX_PT_SUB_TIM 12'h04c
`define CCT_IDX_PT_MAIN_TIM 12'h04d
`define CCT_IDX_PT_UART 12'h04f
`define CCT_IDX_TX_CRC 12'h058
`define CCT_IDX_REV_DLY 12'h031
`define CCT_IDX_BL1_L 12'h548
`define CCT_IDX_BL1_H 12'h549
`define CCT_IDX_BL2_L 12'h54a
`define CCT_IDX_BL2_H 12'h54b

// reset values
`define CCT_RST_SUB_TIM 8'h26
`define CCT_RST_MAIN_TIM 8'h56
`define CCT_RST_XLATE 8'h00
`define CCT_RST_UART_BYP 8'h42
`define CCT_RST_PT_UART 8'h00
`define CCT_RST_TX_CRC 8'h30
`define CCT_RST_REV_DLY 8'h88
`define CCT_RST_BITLEN 8'h00

// write masks; other bits keep reset value
`define CCT_WMASK_TIM8 8'h37
`define CCT_WMASK_MAIN8 8'h77
`define CCT_WMASK_ADDR 8'hfe
`define CCT_WMASK_UART 8'h3f
`define CCT_WMASK_PT_UART 8'hcc
`define CCT_WMASK_TX_CRC 8'h80
`define CCT_WMASK_REV 8'h3f

// field positions
`define CCT_F_SH_LO 4
`define CCT_F_BT_LO 4
`define CCT_F_BYP_EN 0
`define CCT_F_BYP_TO_LO 1
`define CCT_F_BYP_PAR 3
`define CCT_F_LOC_MS 4
`define CCT_F_REM_MS 5
`define CCT_F_PAR1 2
`define CCT_F_CUST1 3
`define CCT_F_PAR2 6
`define CCT_F_CUST2 7
`define CCT_F_TX_CRC 7
`define CCT_TMO_OFF 3'h7
`define CCT_BYP_OFF 2'h3

// times in microseconds
`define CCT_TMO_US0 16
`define CCT_TMO_US1 1000
`define CCT_TMO_US2 2000
`define CCT_TMO_US3 4000
`define CCT_TMO_US4 8000
`define CCT_TMO_US5 16000
`define CCT_TMO_US6 32000
`define CCT_BYP_US0 2000
`define CCT_BYP_US1 8000
`define CCT_BYP_US2 32000

// reverse compensation step, 1.7 us
`define CCT_REV_STEP_NS 1700
`define CCT_REV_STEP_CYC ((`CCT_REV_STEP_NS * `CCT_CLK_MHZ) / 1000)

// main bit rates in bit/s; half period rounds down
`define CCT_HALF(bps) ((`CCT_CLK_MHZ * 1000000) / (2 * (bps)))
`define CCT_BPS0 9920
`define CCT_BPS1 33200
`define CCT_BPS2 99200
`define CCT_BPS3 123000
`define CCT_BPS4 203000
`define CCT_BPS5 397000
`define CCT_BPS6 625000
`define CCT_BPS7 980000

// sda/scl spacing, a quarter bit
`define CCT_SH_NS0 250
`define CCT_SH_NS1 625
`define CCT_SH_NS2 2500
`define CCT_SH_CYC(ns) (((ns) * `CCT_CLK_MHZ + 999) / 1000)

// bit length without custom rate
`define CCT_STD_BITLEN 16'h00c8

`endif

// ==== src/cct_pkg.sv ====
// types and decode functions for the tunnel block
// assumes cct_params.svh is on the include path
package cct_pkg;
`include "cct_params.svh"

typedef enum logic [0:0] {CCT_T_IDLE, CCT_T_WAIT} cct_tmo_state_t;

typedef struct packed {
    logic valid;
    logic [6:0] addr;
} cct_i2c_req_t;

function automatic logic [15:0] cct_tmo_us(input logic [2:0] code);
    case (code)
        3'h0: cct_tmo_us = 16'(`CCT_TMO_US0);
        3'h1: cct_tmo_us = 16'(`CCT_TMO_US1);
        3'h2: cct_tmo_us = 16'(`CCT_TMO_US2);
        3'h3: cct_tmo_us = 16'(`CCT_TMO_US3);
        3'h4: cct_tmo_us = 16'(`CCT_TMO_US4);
        3'h5: cct_tmo_us = 16'(`CCT_TMO_US5);
        default: cct_tmo_us = 16'(`CCT_TMO_US6);
    endcase
endfunction

endpackage

// ==== src/cct_tmo_timer.sv ====
// response-wait timer for one tunnelled channel
// assumes a one-cycle microsecond tick
`timescale 1ns/1ps
`default_nettype none
module cct_tmo_timer
    import cct_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic us_tick,
    input wire logic start,
    input wire logic resp,
    input wire logic [2:0] code,
    output logic busy_r,
    output logic expired_r
);
    cct_tmo_state_t state_r;
    logic [15:0] cnt_r;
    logic hit;

    // a response in the expiry cycle wins
    assign hit = us_tick && (code != `CCT_TMO_OFF) && (cnt_r >= cct_tmo_us(code) - 16'h0001);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= CCT_T_IDLE;
            cnt_r <= 16'h0000;
            expired_r <= 1'b0;
        end
        else
        begin
            expired_r <= 1'b0;
            case (state_r)
                CCT_T_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= CCT_T_WAIT;
                        cnt_r <= 16'h0000;
                    end
                end
                CCT_T_WAIT:
                begin
                    if (resp)
                        state_r <= CCT_T_IDLE;
                    else if (hit)
                    begin
                        state_r <= CCT_T_IDLE;
                        expired_r <= 1'b1;
                    end
                    else if (us_tick && cnt_r != 16'hffff)
                        cnt_r <= cnt_r + 16'h0001;
                end
                default: state_r <= CCT_T_IDLE;
            endcase
        end
    end

    assign busy_r = (state_r == CCT_T_WAIT);
endmodule
`default_nettype wire

// ==== src/cct_tunnel_cfg.sv ====
// tunnel configuration: apb registers, i2c timing, timeouts,
// address translation, uart bypass, reverse delay
// assumes apb master and tunnel inputs on core_clk
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - reverse delay is (multiplier+1) times 1.7us
// - subordinate sda/scl spacing from two-bit speed
// - subordinate waits time out per three-bit code
// - main scl rate from three-bit code
// - pass-through channels share own main rate
// - main waits time out per three-bit code
// - source A address becomes destination A
// - source B address becomes destination B
// - remote gpio level selects uart bypass
// - local pin two selects uart bypass
// - bypass blocks control channel, base allows
// - bypass parity option drops parity bit
// - soft-bypass idle timeout 2, 8, 32ms, or never
// - idle soft-bypass exits and clears enable
// - per-channel pass-through parity disable
// - custom rate bit uses programmed bit length
// - transmit crc enable, reset zero
module cct_tunnel_cfg
    import cct_pkg::*;
#(
    parameter int TICK_CYCLES = `CCT_US_CYC,
    parameter int REV_STEP_CYCLES = `CCT_REV_STEP_CYC
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cct_i2c_req_t xlate_req,
    output cct_i2c_req_t xlate_out,
    input wire logic [3:0] wait_start,
    input wire logic [3:0] resp_rcvd,
    output logic [3:0] chan_busy,
    output logic [3:0] chan_timeout,
    input wire logic [1:0] scl_run,
    output logic [1:0] scl_tick,
    output logic [9:0] sub_sh_cycles_main,
    output logic [9:0] sub_sh_cycles_pt,
    input wire logic gpio_rev_event,
    output logic gpio_rev_out,
    input wire logic remote_ms_level,
    input wire logic mode_select_pin_two,
    input wire logic uart_activity,
    input wire logic power_down_input_n,
    output logic uart_bypass,
    output logic cc_access_en,
    output logic bypass_parity_en,
    output logic [1:0] pt_parity_en,
    output logic [15:0] bitlen_ch1,
    output logic [15:0] bitlen_ch2,
    output logic tx_crc_en
);
    logic [7:0] sub_tim_r, main_tim_r, xlate_source_a_r, xlate_dest_a_r, xlate_source_b_r, xlate_dest_b_r;
    logic [7:0] uart_byp_r, pt_sub_tim_r, pt_main_tim_r, pt_uart_r, tx_crc_r, rev_dly_r;
    logic [7:0] bl1_l_r, bl1_h_r, bl2_l_r, bl2_h_r;
    logic [7:0] rd_nxt;
    logic [11:0] idx;
    logic wr_go, byp_wr;
    logic [15:0] tick_cnt_r;
    logic us_tick_r;
    logic [15:0] idle_cnt_r;
    logic [15:0] rev_cnt_r;
    logic rev_run_r;
    logic [13:0] scl_cnt_r [2];
    logic [2:0] tmo_code [4];

    function automatic logic mapped(input logic [15:0] a);
        logic [11:0] i;
        i = a[13:2];
        mapped = (a[15:14] == 2'b00) &&
            (i == `CCT_IDX_SUB_TIM || i == `CCT_IDX_MAIN_TIM || i == `CCT_IDX_XLATE_SOURCE_A ||
             i == `CCT_IDX_XLATE_DEST_A || i == `CCT_IDX_XLATE_SOURCE_B || i == `CCT_IDX_XLATE_DEST_B ||
             i == `CCT_IDX_UART_BYP || i == `CCT_IDX_PT_SUB_TIM || i == `CCT_IDX_PT_MAIN_TIM ||
             i == `CCT_IDX_PT_UART || i == `CCT_IDX_TX_CRC || i == `CCT_IDX_REV_DLY ||
             i == `CCT_IDX_BL1_L || i == `CCT_IDX_BL1_H || i == `CCT_IDX_BL2_L ||
             i == `CCT_IDX_BL2_H);
    endfunction

    function automatic logic [13:0] half_cyc(input logic [2:0] code);
        case (code)
            3'h0: half_cyc = 14'(`CCT_HALF(`CCT_BPS0));
            3'h1: half_cyc = 14'(`CCT_HALF(`CCT_BPS1));
            3'h2: half_cyc = 14'(`CCT_HALF(`CCT_BPS2));
            3'h3: half_cyc = 14'(`CCT_HALF(`CCT_BPS3));
            3'h4: half_cyc = 14'(`CCT_HALF(`CCT_BPS4));
            3'h5: half_cyc = 14'(`CCT_HALF(`CCT_BPS5));
            3'h6: half_cyc = 14'(`CCT_HALF(`CCT_BPS6));
            default: half_cyc = 14'(`CCT_HALF(`CCT_BPS7));
        endcase
    endfunction

    function automatic logic [9:0] sh_cyc(input logic [1:0] code);
        case (code)
            2'h0: sh_cyc = 10'(`CCT_SH_CYC(`CCT_SH_NS0));
            2'h1: sh_cyc = 10'(`CCT_SH_CYC(`CCT_SH_NS1));
            // reserved code: slowest spacing
            default: sh_cyc = 10'(`CCT_SH_CYC(`CCT_SH_NS2));
        endcase
    endfunction

    assign idx = paddr[13:2];
    // writes land where the access phase sees pready
    assign wr_go = psel && penable && pready && pwrite && !pslverr;
    assign byp_wr = wr_go && idx == `CCT_IDX_UART_BYP;

    // apb: one wait-free access phase, data registered in setup
    always_comb
    begin
        case (idx)
            `CCT_IDX_SUB_TIM: rd_nxt = sub_tim_r;
            `CCT_IDX_MAIN_TIM: rd_nxt = main_tim_r;
            `CCT_IDX_XLATE_SOURCE_A: rd_nxt = xlate_source_a_r;
            `CCT_IDX_XLATE_DEST_A: rd_nxt = xlate_dest_a_r;
            `CCT_IDX_XLATE_SOURCE_B: rd_nxt = xlate_source_b_r;
            `CCT_IDX_XLATE_DEST_B: rd_nxt = xlate_dest_b_r;
            `CCT_IDX_UART_BYP: rd_nxt = uart_byp_r;
            `CCT_IDX_PT_SUB_TIM: rd_nxt = pt_sub_tim_r;
            `CCT_IDX_PT_MAIN_TIM: rd_nxt = pt_main_tim_r;
            `CCT_IDX_PT_UART: rd_nxt = pt_uart_r;
            `CCT_IDX_TX_CRC: rd_nxt = tx_crc_r;
            `CCT_IDX_REV_DLY: rd_nxt = rev_dly_r;
            `CCT_IDX_BL1_L: rd_nxt = bl1_l_r;
            `CCT_IDX_BL1_H: rd_nxt = bl1_h_r;
            `CCT_IDX_BL2_L: rd_nxt = bl2_l_r;
            `CCT_IDX_BL2_H: rd_nxt = bl2_h_r;
            default: rd_nxt = 8'h00;
        endcase
        if (paddr[15:14] != 2'b00)
            rd_nxt = 8'h00;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata <= {24'h00_0000, rd_nxt};
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sub_tim_r <= `CCT_RST_SUB_TIM;
            main_tim_r <= `CCT_RST_MAIN_TIM;
            xlate_source_a_r <= `CCT_RST_XLATE;
            xlate_dest_a_r <= `CCT_RST_XLATE;
            xlate_source_b_r <= `CCT_RST_XLATE;
            xlate_dest_b_r <= `CCT_RST_XLATE;
            pt_sub_tim_r <= `CCT_RST_SUB_TIM;
            pt_main_tim_r <= `CCT_RST_MAIN_TIM;
            pt_uart_r <= `CCT_RST_PT_UART;
            tx_crc_r <= `CCT_RST_TX_CRC;
            rev_dly_r <= `CCT_RST_REV_DLY;
            bl1_l_r <= `CCT_RST_BITLEN;
            bl1_h_r <= `CCT_RST_BITLEN;
            bl2_l_r <= `CCT_RST_BITLEN;
            bl2_h_r <= `CCT_RST_BITLEN;
        end
        else if (wr_go)
        begin
            case (idx)
                `CCT_IDX_SUB_TIM:
                    sub_tim_r <= (pwdata[7:0] & `CCT_WMASK_TIM8) | (sub_tim_r & ~`CCT_WMASK_TIM8);
                `CCT_IDX_MAIN_TIM:
                    main_tim_r <= (pwdata[7:0] & `CCT_WMASK_MAIN8) | (main_tim_r & ~`CCT_WMASK_MAIN8);
                `CCT_IDX_XLATE_SOURCE_A: xlate_source_a_r <= pwdata[7:0] & `CCT_WMASK_ADDR;
                `CCT_IDX_XLATE_DEST_A: xlate_dest_a_r <= pwdata[7:0] & `CCT_WMASK_ADDR;
                `CCT_IDX_XLATE_SOURCE_B: xlate_source_b_r <= pwdata[7:0] & `CCT_WMASK_ADDR;
                `CCT_IDX_XLATE_DEST_B: xlate_dest_b_r <= pwdata[7:0] & `CCT_WMASK_ADDR;
                `CCT_IDX_PT_SUB_TIM:
                    pt_sub_tim_r <= (pwdata[7:0] & `CCT_WMASK_TIM8) | (pt_sub_tim_r & ~`CCT_WMASK_TIM8);
                `CCT_IDX_PT_MAIN_TIM:
                    pt_main_tim_r <= (pwdata[7:0] & `CCT_WMASK_MAIN8) | (pt_main_tim_r & ~`CCT_WMASK_MAIN8);
                `CCT_IDX_PT_UART: pt_uart_r <= pwdata[7:0] & `CCT_WMASK_PT_UART;
                `CCT_IDX_TX_CRC:
                    tx_crc_r <= (pwdata[7:0] & `CCT_WMASK_TX_CRC) | (tx_crc_r & ~`CCT_WMASK_TX_CRC);
                `CCT_IDX_REV_DLY:
                    rev_dly_r <= (pwdata[7:0] & `CCT_WMASK_REV) | (rev_dly_r & ~`CCT_WMASK_REV);
                `CCT_IDX_BL1_L: bl1_l_r <= pwdata[7:0];
                `CCT_IDX_BL1_H: bl1_h_r <= pwdata[7:0];
                `CCT_IDX_BL2_L: bl2_l_r <= pwdata[7:0];
                `CCT_IDX_BL2_H: bl2_h_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // microsecond time base
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_r <= 16'h0000;
            us_tick_r <= 1'b0;
        end
        else if (tick_cnt_r >= 16'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= 16'h0000;
            us_tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            us_tick_r <= 1'b0;
        end
    end

    // waits: 0/1 main sub/main, 2/3 pass-through sub/main
    assign tmo_code[0] = sub_tim_r[2:0];
    assign tmo_code[1] = main_tim_r[2:0];
    assign tmo_code[2] = pt_sub_tim_r[2:0];
    assign tmo_code[3] = pt_main_tim_r[2:0];

    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_tmo
            cct_tmo_timer u_tmo (
                .core_clk(core_clk),
                .rst(rst),
                .us_tick(us_tick_r),
                .start(wait_start[g]),
                .resp(resp_rcvd[g]),
                .code(tmo_code[g]),
                .busy_r(chan_busy[g]),
                .expired_r(chan_timeout[g])
            );
        end
    endgenerate

    // scl half-period ticks; channel 1 serves pass-through
    generate
        for (genvar s = 0; s < 2; s++)
        begin : g_scl
            logic [2:0] bt;
            assign bt = (s == 0) ? main_tim_r[`CCT_F_BT_LO +: 3] : pt_main_tim_r[`CCT_F_BT_LO +: 3];
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    scl_cnt_r[s] <= 14'h0000;
                    scl_tick[s] <= 1'b0;
                end
                else if (!scl_run[s])
                begin
                    scl_cnt_r[s] <= 14'h0000;
                    scl_tick[s] <= 1'b0;
                end
                else if (scl_cnt_r[s] >= half_cyc(bt) - 14'h0001)
                begin
                    scl_cnt_r[s] <= 14'h0000;
                    scl_tick[s] <= 1'b1;
                end
                else
                begin
                    scl_cnt_r[s] <= scl_cnt_r[s] + 14'h0001;
                    scl_tick[s] <= 1'b0;
                end
            end
        end
    endgenerate

    // registered option outputs
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sub_sh_cycles_main <= 10'h000;
            sub_sh_cycles_pt <= 10'h000;
            xlate_out <= '0;
            pt_parity_en <= 2'b11;
            bitlen_ch1 <= `CCT_STD_BITLEN;
            bitlen_ch2 <= `CCT_STD_BITLEN;
            tx_crc_en <= 1'b0;
        end
        else
        begin
            sub_sh_cycles_main <= sh_cyc(sub_tim_r[`CCT_F_SH_LO +: 2]);
            sub_sh_cycles_pt <= sh_cyc(pt_sub_tim_r[`CCT_F_SH_LO +: 2]);
            xlate_out.valid <= xlate_req.valid;
            if (xlate_req.addr == xlate_source_a_r[7:1])
                xlate_out.addr <= xlate_dest_a_r[7:1];
            else if (xlate_req.addr == xlate_source_b_r[7:1])
                xlate_out.addr <= xlate_dest_b_r[7:1];
            else
                xlate_out.addr <= xlate_req.addr;
            pt_parity_en[0] <= !pt_uart_r[`CCT_F_PAR1];
            pt_parity_en[1] <= !pt_uart_r[`CCT_F_PAR2];
            bitlen_ch1 <= pt_uart_r[`CCT_F_CUST1] ? {bl1_h_r, bl1_l_r} : `CCT_STD_BITLEN;
            bitlen_ch2 <= pt_uart_r[`CCT_F_CUST2] ? {bl2_h_r, bl2_l_r} : `CCT_STD_BITLEN;
            tx_crc_en <= tx_crc_r[`CCT_F_TX_CRC];
        end
    end

    // soft-bypass enable: software sets, idle or power-down clears;
    // a same-cycle write wins so a fresh enable is never lost
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            uart_byp_r <= `CCT_RST_UART_BYP;
            idle_cnt_r <= 16'h0000;
        end
        else
        begin
            if (uart_activity || !uart_byp_r[`CCT_F_BYP_EN])
                idle_cnt_r <= 16'h0000;
            else if (us_tick_r && idle_cnt_r != 16'hffff)
                idle_cnt_r <= idle_cnt_r + 16'h0001;
            if (byp_wr)
                uart_byp_r <= (pwdata[7:0] & `CCT_WMASK_UART) | (uart_byp_r & ~`CCT_WMASK_UART);
            else if (!power_down_input_n)
                uart_byp_r[`CCT_F_BYP_EN] <= 1'b0;
            else if (uart_byp_r[`CCT_F_BYP_EN] && !uart_activity && us_tick_r)
            begin
                case (uart_byp_r[`CCT_F_BYP_TO_LO +: 2])
                    2'h0: if (idle_cnt_r >= 16'(`CCT_BYP_US0 - 1)) uart_byp_r[`CCT_F_BYP_EN] <= 1'b0;
                    2'h1: if (idle_cnt_r >= 16'(`CCT_BYP_US1 - 1)) uart_byp_r[`CCT_F_BYP_EN] <= 1'b0;
                    2'h2: if (idle_cnt_r >= 16'(`CCT_BYP_US2 - 1)) uart_byp_r[`CCT_F_BYP_EN] <= 1'b0;
                    default: ;
                endcase
            end
        end
    end

    // mode select: remote, then local pin, then soft-bypass
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            uart_bypass <= 1'b0;
            cc_access_en <= 1'b1;
            bypass_parity_en <= 1'b1;
        end
        else
        begin
            if (uart_byp_r[`CCT_F_REM_MS])
            begin
                uart_bypass <= remote_ms_level;
                cc_access_en <= !remote_ms_level;
            end
            else if (uart_byp_r[`CCT_F_LOC_MS])
            begin
                uart_bypass <= mode_select_pin_two;
                cc_access_en <= !mode_select_pin_two;
            end
            else
            begin
                uart_bypass <= uart_byp_r[`CCT_F_BYP_EN];
                cc_access_en <= !uart_byp_r[`CCT_F_BYP_EN];
            end
            bypass_parity_en <= !uart_byp_r[`CCT_F_BYP_PAR];
        end
    end

    // reverse gpio compensation: an event restarts the delay
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rev_cnt_r <= 16'h0000;
            rev_run_r <= 1'b0;
            gpio_rev_out <= 1'b0;
        end
        else
        begin
            gpio_rev_out <= 1'b0;
            if (gpio_rev_event)
            begin
                rev_cnt_r <= 16'h0001;
                rev_run_r <= 1'b1;
            end
            else if (rev_run_r)
            begin
                if (rev_cnt_r >= 16'((32'(rev_dly_r[5:0]) + 1) * REV_STEP_CYCLES))
                begin
                    rev_run_r <= 1'b0;
                    gpio_rev_out <= 1'b1;
                end
                else
                    rev_cnt_r <= rev_cnt_r + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/cct_far_end.sv ====
// far-end link device model: answers tunnelled waits
// assumes wait_start pulses from the bench; answer=0 models a silent far end
`timescale 1ns/1ps
`default_nettype none
module cct_far_end (
    input wire logic core_clk,
    input wire logic [3:0] wait_start,
    input wire logic answer,
    output logic [3:0] resp_rcvd
);
    logic [3:0] pend_r;
    // a reply takes two cycles, never on the start edge
    always_ff @(posedge core_clk)
    begin
        pend_r <= wait_start | (pend_r & ~{4{answer}});
        resp_rcvd <= pend_r & {4{answer}};
    end
endmodule
`default_nettype wire

// ==== bench/cct_tunnel_cfg_assertions.sv ====
// port checker for the tunnel block
// assumes one core_clk domain, rst active high
`timescale 1ns/1ps
`default_nettype none
module cct_tunnel_cfg_assertions
    import cct_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire cct_i2c_req_t xlate_req,
    input wire cct_i2c_req_t xlate_out,
    input wire logic [3:0] wait_start,
    input wire logic [3:0] resp_rcvd,
    input wire logic [3:0] chan_busy,
    input wire logic [3:0] chan_timeout,
    input wire logic gpio_rev_out,
    input wire logic uart_bypass,
    input wire logic cc_access_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    apb_answer_a: assert property (apb_setup_s |=> pready)
        else $error("no pready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    wait_arm_a: assert property (wait_start[0] && !chan_busy[0] && !resp_rcvd[0] |=> chan_busy[0])
        else $error("wait not armed");
    resp_end_a: assert property (chan_busy[1] && resp_rcvd[1] |=> !chan_busy[1] && !chan_timeout[1])
        else $error("wait not ended");
    tmo_idle_a: assert property (chan_timeout[0] |-> !chan_busy[0] ##1 !chan_timeout[0])
        else $error("busy after timeout");
    xlate_valid_a: assert property (xlate_req.valid |=> xlate_out.valid)
        else $error("no forward");
    access_mode_a: assert property (cc_access_en != uart_bypass)
        else $error("access mismatch");
    rev_pulse_a: assert property (gpio_rev_out |=> !gpio_rev_out)
        else $error("reverse not a pulse");
endmodule
bind cct_tunnel_cfg cct_tunnel_cfg_assertions u_cct_tunnel_cfg_assertions (.core_clk, .rst, .psel,
    .penable, .pready, .xlate_req, .xlate_out, .wait_start, .resp_rcvd, .chan_busy, .chan_timeout,
    .gpio_rev_out, .uart_bypass, .cc_access_en);
`default_nettype wire

// ==== bench/cct_tunnel_cfg_tb.sv ====
// self-checking bench for the tunnel configuration block
// assumes shortened tick and reverse step parameters
`timescale 1ns/1ps
`default_nettype none
module cct_tunnel_cfg_tb;
    import cct_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, answer, er;
    logic gpio_rev_event, gpio_rev_out, remote_ms_level, mode_select_pin_two, uart_activity;
    logic power_down_input_n, uart_bypass, cc_access_en, bypass_parity_en, tx_crc_en;
    logic [15:0] paddr, bitlen_ch1, bitlen_ch2;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] wait_start, resp_rcvd, chan_busy, chan_timeout;
    logic [1:0] scl_run, scl_tick, pt_parity_en;
    logic [9:0] sub_sh_cycles_main, sub_sh_cycles_pt;
    cct_i2c_req_t xlate_req, xlate_out;
    int num_errors = 0, checks_done = 0, cyc = 0, n;
    cct_tunnel_cfg #(.TICK_CYCLES(2), .REV_STEP_CYCLES(4)) u_cct_tunnel_cfg (.*);
    cct_far_end u_cct_far_end (.core_clk, .wait_start, .answer, .resp_rcvd);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] ix, input logic [7:0] wd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic t_regs;
        logic [11:0] ix[6] = '{12'h040, 12'h041, 12'h048, 12'h04d, 12'h058, 12'h031};
        logic [7:0] rv[6] = '{8'h26, 8'h56, 8'h42, 8'h56, 8'h30, 8'h88};
        foreach (ix[i])
        begin
            apb(1'h0, ix[i], 8'h00);
            chk("reset value", {24'h0, rv[i]}, rd);
        end
        apb(1'h0, 12'h07f, 8'h00);
        chk("unmapped error", 1, er);
        apb(1'h1, 12'h058, 8'hff);
        apb(1'h0, 12'h058, 8'h00);
        chk("crc reg", 32'hb0, rd);
        chk("crc enable", 1, tx_crc_en);
        chk("spacing", 32'h1f4, sub_sh_cycles_main);
        $display("registers done");
    endtask
    task automatic xo(input logic [6:0] a, input logic [6:0] e);
        xlate_req <= {1'h1, a};
        @(posedge core_clk);
        xlate_req <= '0;
        @(posedge core_clk);
        chk("translated addr", e, xlate_out.addr);
    endtask
    task automatic t_xlate;
        apb(1'h1, 12'h042, 8'h42);
        apb(1'h1, 12'h043, 8'h66);
        apb(1'h1, 12'h044, 8'h44);
        apb(1'h1, 12'h045, 8'h88);
        xo(7'h21, 7'h33);
        xo(7'h22, 7'h44);
        xo(7'h10, 7'h10);
        $display("translation done");
    endtask
    task automatic t_tmo;
        apb(1'h1, 12'h040, 8'h20);
        apb(1'h1, 12'h041, 8'h57);
        wait_start <= 4'h3;
        @(posedge core_clk);
        wait_start <= 4'h0;
        n = 0;
        do @(posedge core_clk); while (chan_timeout[0] !== 1'h1 && ++n < 99);
        chk("sub timeout", 1, n inside {[29:36]});
        chk("main wait held", 4'h2, chan_busy);
        answer <= 1'h1;
        repeat (4) @(posedge core_clk);
        chk("answered", 4'h0, chan_busy | chan_timeout);
        answer <= 1'h0;
        $display("timeouts done");
    endtask
    task automatic t_rev;
        apb(1'h1, 12'h031, 8'h02);
        gpio_rev_event <= 1'h1;
        @(posedge core_clk);
        gpio_rev_event <= 1'h0;
        n = 0;
        do @(posedge core_clk); while (gpio_rev_out !== 1'h1 && ++n < 99);
        chk("reverse delay", 1, n inside {[11:14]});
        $display("reverse delay done");
    endtask
    task automatic t_byp;
        mode_select_pin_two <= 1'h1;
        apb(1'h1, 12'h048, 8'h18);
        chk("local bypass", 3'h4, {uart_bypass, cc_access_en, bypass_parity_en});
        apb(1'h1, 12'h048, 8'h20);
        chk("remote base", 2'h1, {uart_bypass, cc_access_en});
        apb(1'h1, 12'h048, 8'h01);
        uart_activity <= 1'h1;
        repeat (500) @(posedge core_clk);
        chk("soft bypass", 1, uart_bypass);
        uart_activity <= 1'h0;
        n = 0;
        do @(posedge core_clk); while (uart_bypass !== 1'h0 && ++n < 5000);
        chk("idle exit", 1, n inside {[3990:4010]});
        apb(1'h0, 12'h048, 8'h00);
        chk("enable cleared", 32'h40, rd);
        $display("bypass done");
    endtask
    task automatic t_pt;
        apb(1'h1, 12'h548, 8'h34);
        apb(1'h1, 12'h549, 8'h12);
        apb(1'h1, 12'h04f, 8'h4c);
        chk("custom length", 32'h1234, bitlen_ch1);
        chk("std length", 32'hc8, bitlen_ch2);
        chk("pt parity", 2'h0, pt_parity_en);
        $display("pass-through done");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            num_errors++;
            close_out;
        end
    end
    initial
    begin
        {psel, penable, pwrite, answer, gpio_rev_event, remote_ms_level, uart_activity} = '0;
        {mode_select_pin_two, power_down_input_n, paddr, pwdata} = {2'h1, 48'h0};
        {wait_start, scl_run, xlate_req} = '0;
        rst = 1'h1;
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        t_regs;
        t_xlate;
        t_tmo;
        t_rev;
        t_byp;
        t_pt;
        close_out;
    end
endmodule
`default_nettype wire
